// file: mka_local_adjust.sv
`timescale 1ns/10ps
module mka_local_adjust
   import mka_pkg::*;
#(
   parameter longint HOLD = HOLD_CYC,
   parameter longint DEB = DEB_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [AW-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic key_nav_i,
   input wire logic key_pick_i,
   input wire logic [1:0] jumper_i,
   input wire logic display_i,
   input wire logic [PW-1:0] pressure_i,
   output logic nv_wr_o,
   output mka_range_t nv_data_o,
   output logic menu_active_o,
   output logic [1:0] menu_level_o,
   output logic [2:0] menu_item_o,
   output logic pick_o,
   output logic [2:0] pick_item_o,
   output logic wp_o
);
   localparam int HW = $clog2(HOLD + 1);

   typedef enum logic {ST_MEASURE, ST_BROWSE} mka_state_t;

   mka_state_t state;
   logic [1:0] keys;
   logic nav;
   logic pick;
   logic nav_d;
   logic pick_d;
   logic nav_rise;
   logic pick_rise;
   logic [HW-1:0] hold_cnt;
   logic hold_fire;
   logic loop_mode;
   logic simple_en;
   logic complete_en;
   logic local_en;
   logic menu_ok;
   logic sensing_only_mode_simple;
   logic zero_req;
   logic span_req;
   logic [1:0] level;
   logic [2:0] item;
   logic [2:0] first_item;
   logic [2:0] step_item;
   logic [2:0] step_sub;
   logic [31:0] wmask;
   logic [31:0] rdata;
   logic acc;
   logic wr;
   logic [2:0] last_pick;
   mka_range_t range;
   logic [PW-1:0] max_lim;
   logic rng_done;

   ////////////////////////////////////////////////////////////////////
   // key conditioning

   // one filter per magnetic key
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_key
         mka_key_filter #(
            .CNT(int'(DEB))
         ) u_filt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .raw_i(g == 0 ? key_nav_i : key_pick_i),
            .level_o(keys[g])
         );
      end
   endgenerate

   assign nav = keys[0];
   assign pick = keys[1];
   assign nav_rise = nav & ~nav_d;
   assign pick_rise = pick & ~pick_d;

   // edge history of filtered keys
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nav_d <= 1'b0;
         pick_d <= 1'b0;
      end
      else
      begin
         nav_d <= nav;
         pick_d <= pick;
      end
   end

   // hold timer, restarts when the pressed set changes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hold_cnt <= '0;
      else if ((nav ^ pick) == 1'b0 || nav_rise || pick_rise || hold_fire)
         hold_cnt <= '0;
      else
         hold_cnt <= hold_cnt + 1'b1;
   end

   assign hold_fire = (nav ^ pick) && hold_cnt == HW'(HOLD - 1);

   ////////////////////////////////////////////////////////////////////
   // adjustment mode decode

   always_comb
   begin
      simple_en = !display_i || jumper_i == JMP_SIMPLE;
      complete_en = display_i && jumper_i == JMP_COMPLETE;
      local_en = (simple_en || complete_en) && !(loop_mode && !display_i);
      menu_ok = local_en && (complete_en || loop_mode);
      sensing_only_mode_simple = local_en && simple_en && !loop_mode;
      wp_o = jumper_i == JMP_WP;
   end

   // simple transmitter: held nav sets low, held pick sets high
   assign zero_req = sensing_only_mode_simple && state == ST_MEASURE && hold_fire && nav;
   assign span_req = sensing_only_mode_simple && state == ST_MEASURE && hold_fire && pick;

   ////////////////////////////////////////////////////////////////////
   // main menu item selection

   // whether a main entry is offered
   function automatic logic offered(input logic [2:0] it, input logic lm, input logic cm);
      logic ok;
      ok = it < 3'(NUM_MAIN);
      if (!lm && (it == M_LOOP_RUN || it == M_TUNE))
         ok = 1'b0;
      if (lm && !cm && !(it == M_LOOP_RUN || it == M_TOTAL || it == M_ESC))
         ok = 1'b0;
      return ok;
   endfunction : offered

   // next offered entry after cur, wrapping
   function automatic logic [2:0] next_offered(input logic [2:0] cur, input logic lm,
                                               input logic cm);
      logic [2:0] res;
      logic found;
      logic [2:0] cand;
      res = cur;
      found = 1'b0;
      for (int i = 1; i <= NUM_MAIN; i++)
      begin
         cand = 3'((int'(cur) + i) % NUM_MAIN);
         if (!found && offered(cand, lm, cm))
         begin
            res = cand;
            found = 1'b1;
         end
      end
      return res;
   endfunction : next_offered

   always_comb
   begin
      first_item = next_offered(3'(NUM_MAIN - 1), loop_mode, complete_en);
      step_item = next_offered(item, loop_mode, complete_en);
      step_sub = (item == 3'(SUB_ITEMS - 1)) ? 3'h0 : item + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // menu walker

   // browse state, level and shown item
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= ST_MEASURE;
         level <= 2'h0;
         item <= 3'h0;
      end
      else if (!menu_ok)
      begin
         state <= ST_MEASURE;
         level <= 2'h0;
         item <= 3'h0;
      end
      else
      begin
         unique case (state)
            ST_MEASURE:
               if (nav_rise)
               begin
                  state <= ST_BROWSE;
                  level <= 2'h0;
                  item <= first_item;
               end
            ST_BROWSE:
               if (pick_rise)
               begin
                  if (level == 2'h0 && item == M_ESC)
                     state <= ST_MEASURE;
                  else if (level != 2'h0 && item == 3'(SUB_ITEMS - 1))
                  begin
                     level <= level - 2'h1;
                     item <= (level == 2'h1) ? first_item : 3'h0;
                  end
                  else if (level != 2'(LEVELS - 1))
                  begin
                     level <= level + 2'h1;
                     item <= 3'h0;
                  end
               end
               else if (nav_rise || (hold_fire && nav))
                  item <= (level == 2'h0) ? step_item : step_sub;
         endcase
      end
   end

   // activation pulse for the shown item
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pick_o <= 1'b0;
         pick_item_o <= 3'h0;
      end
      else
      begin
         pick_o <= menu_ok && state == ST_BROWSE && pick_rise;
         if (menu_ok && state == ST_BROWSE && pick_rise)
            pick_item_o <= item;
      end
   end

   assign menu_active_o = state == ST_BROWSE;
   assign menu_level_o = level;
   assign menu_item_o = item;

   ////////////////////////////////////////////////////////////////////
   // range store and nonvolatile commit

   mka_rerange u_rng (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .zero_i(zero_req),
      .span_i(span_req),
      .pressure_i(pressure_i),
      .wr_low_i(wr && adr_i == ADR_LOW),
      .wr_high_i(wr && adr_i == ADR_HIGH),
      .wr_max_i(wr && adr_i == ADR_MAX),
      .wdata_i(PW'((32'(adr_i == ADR_HIGH ? range.high : adr_i == ADR_MAX ? max_lim : range.low)
                   & ~wmask) | (dat_i & wmask))),
      .range_o(range),
      .max_o(max_lim),
      .done_o(rng_done)
   );

   // nonvolatile write strobe, suppressed while protected
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nv_wr_o <= 1'b0;
         nv_data_o <= '0;
      end
      else
      begin
         nv_wr_o <= rng_done && !wp_o;
         nv_data_o <= range;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone slave

   assign acc = cyc_i && stb_i && !ack_o;
   assign wr = acc && we_i;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   // read mux, unmapped reads zero
   always_comb
   begin
      unique case (adr_i)
         ADR_CTRL: rdata = {31'h0000_0000, loop_mode};
         ADR_STATUS: rdata = {21'h0_0000, wp_o, complete_en, simple_en, local_en,
                              menu_active_o, level, item, 1'b0};
         ADR_LOW: rdata = 32'(range.low);
         ADR_HIGH: rdata = 32'(range.high);
         ADR_MAX: rdata = 32'(max_lim);
         ADR_PICK: rdata = 32'(last_pick);
         default: rdata = 32'h0000_0000;
      endcase
   end

   // one cycle ack, registered read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= acc;
         if (acc)
            dat_o <= rdata;
      end
   end

   // operating mode bit and last activated item
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         loop_mode <= RST_CTRL[CTRL_LOOP_MODE];
         last_pick <= 3'h0;
      end
      else
      begin
         if (wr && adr_i == ADR_CTRL && sel_i[0])
            loop_mode <= dat_i[CTRL_LOOP_MODE];
         if (pick_o)
            last_pick <= pick_item_o;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_enter;
      state == ST_MEASURE && menu_ok && nav_rise;
   endsequence

   sequence s_zero;
      zero_req;
   endsequence

   a_lock_keys: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_mode && !display_i |=> state == ST_MEASURE && !pick_o)
      else $error("keys acted in controller mode without display");

   a_ctrl_items: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_BROWSE && level == 2'h0 && loop_mode && !complete_en
      |-> item == M_LOOP_RUN || item == M_TOTAL || item == M_ESC)
      else $error("simple controller showed forbidden entry");

   a_wp_block: assert property (@(posedge clk_i) disable iff (rst_i)
      nv_wr_o |-> $past(jumper_i) != JMP_WP)
      else $error("nonvolatile write while protected");

   a_default_jumper: assert property (@(posedge clk_i) disable iff (rst_i)
      jumper_i == JMP_SIMPLE |-> simple_en && !wp_o)
      else $error("default jumpers not simple unprotected");

   a_menu_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      s_enter |=> state == ST_BROWSE && level == 2'h0
                  && (loop_mode || item == M_SETUP))
      else $error("menu entry wrong");

   a_branch_enter: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_BROWSE && menu_ok && pick_rise && level == 2'h0 && item != M_ESC
      |=> level == 2'h1 && item == 3'h0 && pick_o)
      else $error("pick did not enter branch");

   a_nav_step: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_BROWSE && menu_ok && nav_rise && !pick_rise |=> item != $past(item))
      else $error("navigation did not step");

   a_no_display: assert property (@(posedge clk_i) disable iff (rst_i)
      !display_i |-> simple_en && !complete_en)
      else $error("display absent but complete or no simple");

   a_zero_low: assert property (@(posedge clk_i) disable iff (rst_i)
      s_zero |-> sensing_only_mode_simple ##1 range.low == $past(pressure_i)
      ##1 nv_wr_o == !$past(wp_o) && nv_data_o.low == $past(pressure_i, 2))
      else $error("zero reranging wrong");

   a_zero_span: assert property (@(posedge clk_i) disable iff (rst_i)
      s_zero ##1 1'b1 |-> range.high == (($past(pressure_i) + $past(range.high)
         - $past(range.low)) > {1'b0, $past(max_lim)} ? $past(max_lim)
         : PW'($past(pressure_i) + $past(range.high) - $past(range.low))))
      else $error("zero shift lost span or clamp");

   a_span_high: assert property (@(posedge clk_i) disable iff (rst_i)
      span_req |=> range.high == $past(pressure_i) && range.low == $past(range.low))
      else $error("span reranging wrong");
endmodule : mka_local_adjust

// file: mka_pkg.sv
package mka_pkg;
   // widths of measured pressure and register addresses
   localparam int PW = 16;
   localparam int AW = 8;

   // register byte offsets
   localparam logic [AW-1:0] ADR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADR_STATUS = 8'h04;
   localparam logic [AW-1:0] ADR_LOW = 8'h08;
   localparam logic [AW-1:0] ADR_HIGH = 8'h0c;
   localparam logic [AW-1:0] ADR_MAX = 8'h10;
   localparam logic [AW-1:0] ADR_PICK = 8'h14;

   // values after reset
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [PW-1:0] RST_LOW = 16'h0000;
   localparam logic [PW-1:0] RST_HIGH = 16'h1000;
   localparam logic [PW-1:0] RST_MAX = 16'hffff;

   // field positions
   localparam int CTRL_LOOP_MODE = 0;

   // jumper codes; 0 is the factory position
   localparam logic [1:0] JMP_SIMPLE = 2'h0;
   localparam logic [1:0] JMP_WP = 2'h1;
   localparam logic [1:0] JMP_OFF = 2'h2;
   localparam logic [1:0] JMP_COMPLETE = 2'h3;

   // timing
   localparam longint CLK_HZ = 20_000_000;
   localparam longint HOLD_S = 2;
   localparam longint HOLD_CYC = HOLD_S * CLK_HZ;
   localparam longint DEB_MS = 10;
   localparam longint DEB_CYC = DEB_MS * CLK_HZ / 1000;

   // menu depth and width of sub branches
   localparam int LEVELS = 3;
   localparam int SUB_ITEMS = 8;
   localparam int NUM_MAIN = 6;

   // main menu entries
   typedef enum logic [2:0] {
      M_LOOP_RUN,
      M_TUNE,
      M_SETUP,
      M_TOTAL,
      M_TRIM,
      M_ESC
   } mka_item_t;

   // working range pair
   typedef struct packed {
      logic [PW-1:0] low;
      logic [PW-1:0] high;
   } mka_range_t;
endpackage : mka_pkg

// file: mka_key_filter.sv
`timescale 1ns/10ps
module mka_key_filter
   import mka_pkg::*;
#(
   parameter int CNT = 200000
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic raw_i,
   output logic level_o
);
   localparam int CW = $clog2(CNT + 1);
   logic sync_a;
   logic sync_b;
   logic [CW-1:0] cnt;

   // two stage synchroniser
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else
      begin
         sync_a <= raw_i;
         sync_b <= sync_a;
      end
   end

   // level accepted only after a stable run
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt <= '0;
         level_o <= 1'b0;
      end
      else if (sync_b == level_o)
         cnt <= '0;
      else if (cnt == CW'(CNT - 1))
      begin
         cnt <= '0;
         level_o <= sync_b;
      end
      else
         cnt <= cnt + 1'b1;
   end

   a_filter_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(level_o) |-> $past(cnt) == CW'(CNT - 1) && $past(sync_b) == level_o)
      else $error("key level changed without stable run");
endmodule : mka_key_filter

// file: mka_rerange.sv
`timescale 1ns/10ps
module mka_rerange
   import mka_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic zero_i,
   input wire logic span_i,
   input wire logic [PW-1:0] pressure_i,
   input wire logic wr_low_i,
   input wire logic wr_high_i,
   input wire logic wr_max_i,
   input wire logic [PW-1:0] wdata_i,
   output mka_range_t range_o,
   output logic [PW-1:0] max_o,
   output logic done_o
);
   logic [PW-1:0] span;
   logic [PW:0] shifted;
   logic [PW-1:0] next_high;

   // zero keeps the span, clamped at the sensor limit
   always_comb
   begin
      span = range_o.high - range_o.low;
      shifted = {1'b0, pressure_i} + {1'b0, span};
      if (shifted > {1'b0, max_o})
         next_high = max_o;
      else
         next_high = shifted[PW-1:0];
   end

   // range registers and sensor limit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         range_o <= '{low: RST_LOW, high: RST_HIGH};
         max_o <= RST_MAX;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= zero_i | span_i | wr_low_i | wr_high_i;
         if (zero_i)
         begin
            range_o.low <= pressure_i;
            range_o.high <= next_high;
         end
         else if (span_i)
            range_o.high <= pressure_i;
         else
         begin
            if (wr_low_i)
               range_o.low <= wdata_i;
            if (wr_high_i)
               range_o.high <= wdata_i;
         end
         if (wr_max_i)
            max_o <= wdata_i;
      end
   end
endmodule : mka_rerange

// file: mka_operator.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// operator with a magnetic tool: one hole at a time, levels change on edges
module mka_operator
(
   input wire logic clk_i,
   output logic key_nav_o,
   output logic key_pick_o
);
   logic loop_manual;

   // tool away from both holes at start
   initial
   begin
      key_nav_o = 1'b0;
      key_pick_o = 1'b0;
      loop_manual = 1'b0;
   end

   // place the tool for some cycles, then keep it away for some cycles
   task press(input logic pick, input int hold, input int gap);
   begin
      loop_manual = 1'b1; // loop to manual before adjusting
      @(posedge clk_i);
      if (pick)
      begin
         key_pick_o <= 1'b1;
      end
      else
      begin
         key_nav_o <= 1'b1;
      end
      repeat (hold) @(posedge clk_i);
      key_nav_o <= 1'b0;
      key_pick_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
      loop_manual = 1'b0; // back to automatic afterwards
   end
   endtask : press
endmodule : mka_operator

// file: mka_local_adjust_bench.sv
`timescale 1ns/10ps
module mka_local_adjust_bench;
   import mka_pkg::*;
   // short hold and debounce so the run stays brief
   localparam longint HOLD = 20;
   localparam longint DEB = 4;
   localparam int TAP = 10;
   localparam int GAP = 12;
   localparam int LONG = 32;
   localparam int LIMIT = 20000;
   logic clk_i, rst_i, cyc, stb, we, display, ack_o, nv_wr_o, menu_active_o, pick_o, wp_o;
   logic key_nav, key_pick;
   logic [AW-1:0] adr;
   logic [31:0] dat, dat_o, q;
   logic [3:0] sel;
   logic [1:0] jumper, menu_level_o;
   logic [PW-1:0] pressure;
   logic [2:0] menu_item_o, pick_item_o, last_pick;
   mka_range_t nv_data_o;
   int miscompares = 0;
   int check_count = 0;
   int nv_cnt = 0;
   int pick_cnt = 0;
   int cycles = 0;
   int n0;

   ////////////////////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   mka_local_adjust #(.HOLD(HOLD), .DEB(DEB)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .key_nav_i(key_nav),
      .key_pick_i(key_pick), .jumper_i(jumper), .display_i(display),
      .pressure_i(pressure), .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o),
      .menu_active_o(menu_active_o), .menu_level_o(menu_level_o),
      .menu_item_o(menu_item_o), .pick_o(pick_o), .pick_item_o(pick_item_o), .wp_o(wp_o)
   );

   mka_operator OP (.clk_i(clk_i), .key_nav_o(key_nav), .key_pick_o(key_pick));

   // pulse counters and hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (nv_wr_o === 1'b1) nv_cnt++;
      if (pick_o === 1'b1)
      begin
         pick_cnt++;
         last_pick = pick_item_o;
      end
      if (cycles == LIMIT)
      begin
         miscompares++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
   begin
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   end
   endtask : chk

   // one classic bus cycle; read data lands in q
   task wb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do
      begin
         @(posedge clk_i);
      end
      while (ack_o !== 1'b1);
      q = dat_o;
      chk({31'h0, ack_o}, 32'h0000_0001, "ack");
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   // set jumpers and display under reset, then write the operating mode
   task mode(input logic ctl, input logic [1:0] j, input logic disp);
   begin
      rst_i <= 1'b1;
      jumper <= j;
      display <= disp;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, ADR_CTRL, {31'h0, ctl});
   end
   endtask : mode

   // controller menu walk with a display: expected items, then escape
   task walk(input logic [1:0] j, input int n, input mka_item_t seq [6]);
   begin
      mode(1'b1, j, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         OP.press(1'b0, TAP, GAP);
         chk({29'h0, menu_item_o}, 32'(seq[i]), "item");
      end
      OP.press(1'b1, TAP, GAP);
      chk({31'h0, menu_active_o}, 32'h0000_0000, "escape");
   end
   endtask : walk

   task test_done;
   begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   end
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rst_i = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr = 8'h00;
      dat = 32'h0000_0000;
      sel = 4'h0;
      jumper = JMP_SIMPLE;
      display = 1'b1;
      pressure = 16'h0000;
      mode(1'b0, JMP_SIMPLE, 1'b1);
      wb(1'b0, ADR_LOW, 0);
      chk(q, {16'h0000, RST_LOW}, "low reset");
      wb(1'b0, ADR_HIGH, 0);
      chk(q, {16'h0000, RST_HIGH}, "high reset");
      wb(1'b0, ADR_MAX, 0);
      chk(q, {16'h0000, RST_MAX}, "max reset");
      wb(1'b0, 8'h20, 0);
      chk(q, 32'h0000_0000, "unmapped");
      chk({31'h0, wp_o}, 32'h0000_0000, "no protect");
      wb(1'b0, ADR_STATUS, 0);
      chk(q, 32'h0000_0180, "status simple local");
      $display("test reset values done");
      // zero with complete jumper and no display: simple is forced
      mode(1'b0, JMP_COMPLETE, 1'b0);
      wb(1'b1, ADR_LOW, 32'h0000_0100);
      wb(1'b1, ADR_HIGH, 32'h0000_0400);
      pressure <= 16'h0200;
      OP.press(1'b0, LONG, GAP);
      wb(1'b0, ADR_LOW, 0);
      chk(q, 32'h0000_0200, "zero low");
      wb(1'b0, ADR_HIGH, 0);
      chk(q, 32'h0000_0500, "zero keeps span");
      chk(nv_data_o, 32'h0200_0500, "nv data");
      chk({31'h0, menu_active_o}, 32'h0000_0000, "no menu");
      $display("test zero done");
      // clamp at sensor limit, then span
      mode(1'b0, JMP_OFF, 1'b0);
      wb(1'b1, ADR_MAX, 32'h0000_1800);
      pressure <= 16'h0c00;
      OP.press(1'b0, LONG, GAP);
      wb(1'b0, ADR_HIGH, 0);
      chk(q, 32'h0000_1800, "clamped high");
      pressure <= 16'h1100;
      OP.press(1'b1, LONG, GAP);
      wb(1'b0, ADR_HIGH, 0);
      chk(q, 32'h0000_1100, "span high");
      wb(1'b0, ADR_LOW, 0);
      chk(q, 32'h0000_0c00, "span keeps low");
      $display("test clamp and span done");
      // write protection blocks commits
      mode(1'b0, JMP_WP, 1'b1);
      n0 = nv_cnt;
      wb(1'b1, ADR_LOW, 32'h0000_0123);
      OP.press(1'b0, LONG, GAP);
      chk(nv_cnt, n0, "protected commit");
      chk({31'h0, wp_o}, 32'h0000_0001, "protect flag");
      mode(1'b0, JMP_SIMPLE, 1'b1);
      n0 = nv_cnt;
      wb(1'b1, ADR_LOW, 32'h0000_0123);
      repeat (4) @(posedge clk_i);
      chk(nv_cnt, n0 + 1, "open commit");
      $display("test protect done");
      // controller without display ignores keys
      mode(1'b1, JMP_SIMPLE, 1'b0);
      n0 = pick_cnt;
      pressure <= 16'h0300;
      OP.press(1'b0, LONG, GAP);
      OP.press(1'b1, LONG, GAP);
      wb(1'b0, ADR_LOW, 0);
      chk(q, 32'h0000_0000, "no zero");
      chk({31'h0, menu_active_o}, 32'h0000_0000, "no menu");
      chk(pick_cnt, n0, "no pick");
      $display("test controller blind done");
      // transmitter complete menu
      mode(1'b0, JMP_COMPLETE, 1'b1);
      OP.press(1'b0, 2, GAP);
      chk({31'h0, menu_active_o}, 32'h0000_0000, "glitch");
      OP.press(1'b0, TAP, GAP);
      chk({31'h0, menu_active_o}, 32'h0000_0001, "menu open");
      chk({29'h0, menu_item_o}, 32'(M_SETUP), "first item");
      OP.press(1'b0, TAP, GAP);
      chk({29'h0, menu_item_o}, 32'(M_TOTAL), "next item");
      n0 = pick_cnt;
      OP.press(1'b1, TAP, GAP);
      chk(pick_cnt, n0 + 1, "pick pulse");
      chk({29'h0, last_pick}, 32'(M_TOTAL), "picked");
      chk({30'h0, menu_level_o}, 32'h0000_0001, "level");
      wb(1'b0, ADR_PICK, 0);
      chk(q, 32'(M_TOTAL), "pick register");
      for (int i = 1; i < 8; i++)
      begin
         OP.press(1'b0, TAP, GAP);
         chk({29'h0, menu_item_o}, i, "sub item");
      end
      OP.press(1'b1, TAP, GAP);
      chk({30'h0, menu_level_o}, 32'h0000_0000, "go up");
      for (int i = 0; i < 8 && menu_item_o !== M_ESC; i++) OP.press(1'b0, TAP, GAP);
      OP.press(1'b1, TAP, GAP);
      chk({31'h0, menu_active_o}, 32'h0000_0000, "escape");
      wb(1'b0, ADR_LOW, 0);
      chk(q, 32'h0000_0000, "no rerange");
      $display("test transmitter menu done");
      walk(JMP_SIMPLE, 3, '{M_LOOP_RUN, M_TOTAL, M_ESC, M_ESC, M_ESC, M_ESC});
      walk(JMP_COMPLETE, 6, '{M_LOOP_RUN, M_TUNE, M_SETUP, M_TOTAL, M_TRIM, M_ESC});
      $display("test controller menus done");
      test_done();
   end
endmodule : mka_local_adjust_bench
